// ==== csrc_ctrl.sv ====
// Coherent snoop sequencing and response combining controller
//
// Summary of operation
// - Every accepted transaction gets a read or write response.
// - Cached masters are snooped one after another, never together.
// - Snoop type may differ between masters of one transaction.
// - Sequential snooping allows extra snoop types for unique kinds.
// - After a dirty hand-over, later unique snoops may be MakeInvalid.
// - Snoop type makes each cache end Shared, Clean or Invalid as needed.
// - IsShared is computed for shareable reads only after snooping ends.
// - WasUnique with IsShared gives IsShared set.
// - WasUnique without IsShared gives IsShared clear.
// - Without WasUnique, any snoop IsShared gives IsShared set.
// - Without WasUnique, no IsShared and no data gives IsShared clear.
// - Without WasUnique, data but no IsShared gives clear by default.
// - Dirty snoop data with no memory update sets PassDirty.
// - Each transaction returns only its permitted response bits.
// - ReadNotSharedDirty never returns IsShared with PassDirty.
// - Extra coherency bits travel only on the read response.
// - Forwarded writes return the downstream write response.
// - Evict is not forwarded and is answered OKAY locally.
// - WasUnique is snoop response bit 4, PassDirty bit 2.
// - The initiating master is never snooped.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "csrc_map.svh"

module csrc_ctrl (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB register slave
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Initiating master request
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire csrc_pkg::csrc_req_s req,
  // Snoop request and snoop response
  output logic                     ac_valid,
  input  wire logic                ac_ready,
  output csrc_pkg::csrc_snp_s      ac,
  input  wire logic                cr_valid,
  output logic                     cr_ready,
  input  wire logic [4:0]          cr_resp,
  // Read response to the initiator
  output logic                     r_valid,
  input  wire logic                r_ready,
  output logic      [3:0]          r_resp,
  // Write response to the initiator
  output logic                     b_valid,
  input  wire logic                b_ready,
  output logic      [1:0]          b_resp,
  // Downstream write forwarding
  output logic                     dn_aw_valid,
  input  wire logic                dn_aw_ready,
  output csrc_pkg::csrc_req_s      dn_aw,
  input  wire logic                dn_b_valid,
  output logic                     dn_b_ready,
  input  wire logic [1:0]          dn_b_resp,
  // Memory update of a dirty line
  output logic                     mu_valid,
  input  wire logic                mu_ready,
  output logic      [31:0]         mu_addr
);

  // ******************************************************************
  // Decode functions
  // ******************************************************************
  // Transactions issued on the read address channel
  function automatic logic is_read(input csrc_pkg::csrc_txn_e t);
    is_read = (t <= csrc_pkg::TX_MAKE_INVALID);
  endfunction

  function automatic logic needs_snoop(input csrc_pkg::csrc_txn_e t);
    needs_snoop = (t != csrc_pkg::TX_READ_NO_SNOOP) &&
                  (t <= csrc_pkg::TX_WRITE_LINE_UNIQUE) &&
                  (t != csrc_pkg::TX_WRITE_NO_SNOOP);
  endfunction

  // Kinds that may return IsShared
  function automatic logic may_share(input csrc_pkg::csrc_txn_e t);
    may_share = (t >= csrc_pkg::TX_READ_ONCE &&
                 t <= csrc_pkg::TX_READ_SHARED) ||
                (t == csrc_pkg::TX_CLEAN_SHARED);
  endfunction

  // Kinds that may return PassDirty
  function automatic logic may_dirty(input csrc_pkg::csrc_txn_e t);
    may_dirty = (t == csrc_pkg::TX_READ_NSD) ||
                (t == csrc_pkg::TX_READ_SHARED) ||
                (t == csrc_pkg::TX_READ_UNIQUE);
  endfunction

  // Kinds that may switch to MakeInvalid after a dirty hand-over
  function automatic logic mkinv_ok(input csrc_pkg::csrc_txn_e t);
    mkinv_ok = (t == csrc_pkg::TX_WRITE_UNIQUE) ||
               (t == csrc_pkg::TX_READ_UNIQUE) ||
               (t == csrc_pkg::TX_CLEAN_UNIQUE) ||
               (t == csrc_pkg::TX_CLEAN_INVALID);
  endfunction

  // Recommended snoop per kind; it fixes the end state of the cache
  function automatic csrc_pkg::csrc_snoop_e rec_snoop(
    input csrc_pkg::csrc_txn_e t);
    unique case (t)
      csrc_pkg::TX_READ_ONCE:         rec_snoop = csrc_pkg::SN_READ_ONCE;
      csrc_pkg::TX_READ_CLEAN:        rec_snoop = csrc_pkg::SN_READ_CLEAN;
      csrc_pkg::TX_READ_NSD:          rec_snoop = csrc_pkg::SN_READ_NSD;
      csrc_pkg::TX_READ_SHARED:       rec_snoop = csrc_pkg::SN_READ_SHARED;
      csrc_pkg::TX_READ_UNIQUE:       rec_snoop = csrc_pkg::SN_READ_UNIQUE;
      csrc_pkg::TX_CLEAN_SHARED:      rec_snoop = csrc_pkg::SN_CLEAN_SHARED;
      csrc_pkg::TX_MAKE_UNIQUE,
      csrc_pkg::TX_MAKE_INVALID,
      csrc_pkg::TX_WRITE_LINE_UNIQUE: rec_snoop = csrc_pkg::SN_MAKE_INVALID;
      default:                        rec_snoop = csrc_pkg::SN_CLEAN_INVALID;
    endcase
  endfunction

  function automatic csrc_pkg::csrc_end_e need_state(
    input csrc_pkg::csrc_txn_e t);
    if (!needs_snoop(t) || t == csrc_pkg::TX_READ_ONCE)
      need_state = csrc_pkg::END_NONE;
    else if (t <= csrc_pkg::TX_READ_SHARED)
      need_state = csrc_pkg::END_SHARED_OR_INV;
    else if (t == csrc_pkg::TX_CLEAN_SHARED)
      need_state = csrc_pkg::END_CLEAN_OR_INV;
    else
      need_state = csrc_pkg::END_INVALID;
  endfunction

  // ******************************************************************
  // Registers and state
  // ******************************************************************
  csrc_pkg::csrc_state_e state_r;
  csrc_pkg::csrc_req_s   req_r;
  csrc_pkg::csrc_snp_s   ac_r;
  logic [2:0]            ctrl_r;
  logic [3:0]            mask_r;
  logic [31:0]           count_r;
  logic [31:0]           prdata_r;
  logic [1:0]            idx_r;
  logic                  wu_r, wu_is_r, is_r, dt_r, pd_r, done_r;
  logic [3:0]            r_resp_r;
  logic [1:0]            b_resp_r;
  logic                  mu_need_r;
  logic                  eligible, stop, is_fin, pd_fin;
  logic                  apb_wr, apb_rd, mapped;

  // Target is present and is not the initiator
  assign eligible = mask_r[idx_r] && (idx_r != req_r.src);

  // Early stop: copy obtained, unique holder found, or dirty clean
  assign stop = cr_resp[`CSRC_CR_WU] ||
    (cr_resp[`CSRC_CR_DT] && req_r.txn >= csrc_pkg::TX_READ_ONCE &&
     req_r.txn <= csrc_pkg::TX_READ_SHARED) ||
    (cr_resp[`CSRC_CR_PD] && req_r.txn == csrc_pkg::TX_CLEAN_SHARED);

  // IsShared from the gathered snoop answers; the lean choice is kept
  // unless software asks to report sharing whenever data moved and no snoop returned WasUnique
  assign is_fin = may_share(req_r.txn) &&
    (wu_r ? wu_is_r :
     (is_r || (ctrl_r[`CSRC_CTRL_SHDATA] && dt_r)));

  // PassDirty only where allowed; shared NSD pushes to memory instead
  assign pd_fin = pd_r && may_dirty(req_r.txn) &&
    !(req_r.txn == csrc_pkg::TX_READ_NSD && is_fin);

  // ******************************************************************
  // Transaction sequencer
  // ******************************************************************
  // One snoop outstanding at a time, walking masters by index
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_r <= csrc_pkg::ST_IDLE;
      idx_r   <= 2'h0;
      done_r  <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        csrc_pkg::ST_IDLE:
          if (req_valid && req_ready)
          begin
            idx_r  <= 2'h0;
            done_r <= 1'b0;
            if (needs_snoop(req.txn))
              state_r <= csrc_pkg::ST_PICK;
            else if (is_read(req.txn))
              state_r <= csrc_pkg::ST_RRESP;
            else if (req.txn == csrc_pkg::TX_EVICT)
              state_r <= csrc_pkg::ST_BRESP;
            else
              state_r <= csrc_pkg::ST_DOWN;
          end
        csrc_pkg::ST_PICK:
          if (eligible)
            state_r <= csrc_pkg::ST_SNOOP;
          else if (idx_r == `CSRC_LAST_MID)
            state_r <= csrc_pkg::ST_DONE;
          else
            idx_r <= idx_r + 2'h1;
        csrc_pkg::ST_SNOOP:
          if (ac_ready)
            state_r <= csrc_pkg::ST_WAITCR;
        csrc_pkg::ST_WAITCR:
          if (cr_valid)
          begin
            if (stop || idx_r == `CSRC_LAST_MID)
              state_r <= csrc_pkg::ST_DONE;
            else
            begin
              idx_r   <= idx_r + 2'h1;
              state_r <= csrc_pkg::ST_PICK;
            end
          end
        csrc_pkg::ST_DONE:
        begin
          done_r <= 1'b1;
          if (pd_r && !pd_fin)
            state_r <= csrc_pkg::ST_MEMUPD;
          else if (is_read(req_r.txn))
            state_r <= csrc_pkg::ST_RRESP;
          else
            state_r <= csrc_pkg::ST_DOWN;
        end
        csrc_pkg::ST_MEMUPD:
          if (mu_ready)
            state_r <= is_read(req_r.txn) ? csrc_pkg::ST_RRESP
                                          : csrc_pkg::ST_DOWN;
        csrc_pkg::ST_DOWN:
          if (dn_aw_ready)
            state_r <= csrc_pkg::ST_WAITB;
        csrc_pkg::ST_WAITB:
          if (dn_b_valid)
            state_r <= csrc_pkg::ST_BRESP;
        csrc_pkg::ST_RRESP:
          if (r_ready)
            state_r <= csrc_pkg::ST_IDLE;
        csrc_pkg::ST_BRESP:
          if (b_ready)
            state_r <= csrc_pkg::ST_IDLE;
      endcase
    end

  // Request capture and snoop descriptor build
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      req_r <= '0;
      ac_r  <= '0;
    end
    else if (state_r == csrc_pkg::ST_IDLE && req_valid && req_ready)
      req_r <= req;
    else if (state_r == csrc_pkg::ST_PICK && eligible)
    begin
      // Same line, but the type may change between masters
      ac_r.snoop  <= (pd_r && ctrl_r[`CSRC_CTRL_MKINV] &&
                      mkinv_ok(req_r.txn)) ? csrc_pkg::SN_MAKE_INVALID
                     : rec_snoop(req_r.txn);
      ac_r.need   <= need_state(req_r.txn);
      ac_r.target <= idx_r;
      ac_r.addr   <= req_r.addr;
    end

  // Snoop answer accumulation
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wu_r    <= 1'b0;
      wu_is_r <= 1'b0;
      is_r    <= 1'b0;
      dt_r    <= 1'b0;
      pd_r    <= 1'b0;
    end
    else if (state_r == csrc_pkg::ST_IDLE)
    begin
      wu_r    <= 1'b0;
      wu_is_r <= 1'b0;
      is_r    <= 1'b0;
      dt_r    <= 1'b0;
      pd_r    <= 1'b0;
    end
    else if (state_r == csrc_pkg::ST_WAITCR && cr_valid)
    begin
      if (cr_resp[`CSRC_CR_WU])
      begin
        wu_r    <= 1'b1;
        wu_is_r <= cr_resp[`CSRC_CR_IS];
      end
      is_r <= is_r | cr_resp[`CSRC_CR_IS];
      dt_r <= dt_r | cr_resp[`CSRC_CR_DT];
      pd_r <= pd_r | cr_resp[`CSRC_CR_PD];
    end

  // Response words; registered so the channels see stable data
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      r_resp_r  <= 4'h0;
      b_resp_r  <= `CSRC_BRESP_OKAY;
      mu_need_r <= 1'b0;
    end
    else if (state_r == csrc_pkg::ST_IDLE && req_valid && req_ready)
    begin
      r_resp_r  <= 4'h0;
      b_resp_r  <= `CSRC_BRESP_OKAY;
      mu_need_r <= 1'b0;
    end
    else if (state_r == csrc_pkg::ST_DONE)
    begin
      r_resp_r  <= {is_fin, pd_fin, `CSRC_RESP_OKAY};
      mu_need_r <= pd_r && !pd_fin;
    end
    else if (state_r == csrc_pkg::ST_WAITB && dn_b_valid)
      b_resp_r <= dn_b_resp;

  // ******************************************************************
  // Channel outputs
  // ******************************************************************
  assign req_ready   = (state_r == csrc_pkg::ST_IDLE) &&
                       ctrl_r[`CSRC_CTRL_EN];
  assign ac_valid    = (state_r == csrc_pkg::ST_SNOOP);
  assign ac          = ac_r;
  assign cr_ready    = (state_r == csrc_pkg::ST_WAITCR);
  assign r_valid     = (state_r == csrc_pkg::ST_RRESP);
  assign r_resp      = r_resp_r;
  assign b_valid     = (state_r == csrc_pkg::ST_BRESP);
  assign b_resp      = b_resp_r;
  assign dn_aw_valid = (state_r == csrc_pkg::ST_DOWN);
  assign dn_aw       = req_r;
  assign dn_b_ready  = (state_r == csrc_pkg::ST_WAITB);
  assign mu_valid    = (state_r == csrc_pkg::ST_MEMUPD);
  assign mu_addr     = req_r.addr;

  // ******************************************************************
  // APB register slave
  // ******************************************************************
  // Zero wait states; read data is latched in the setup cycle
  assign mapped  = (paddr == `CSRC_OFS_CTRL) ||
                   (paddr == `CSRC_OFS_MASK) ||
                   (paddr == `CSRC_OFS_STATUS) ||
                   (paddr == `CSRC_OFS_COUNT);
  assign apb_wr  = psel && penable && pwrite && mapped;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_r;

  // Control and mask; changes apply at once, also to a transaction in flight
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_r <= `CSRC_CTRL_RST;
      mask_r <= `CSRC_MASK_RST;
    end
    else if (apb_wr && paddr == `CSRC_OFS_CTRL)
      ctrl_r <= pwdata[2:0];
    else if (apb_wr && paddr == `CSRC_OFS_MASK)
      mask_r <= pwdata[3:0];

  // Completed transaction counter, write clears unless a completion counts in the same cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      count_r <= 32'h0;
    else if ((r_valid && r_ready) || (b_valid && b_ready))
      count_r <= count_r + 32'h1;
    else if (apb_wr && paddr == `CSRC_OFS_COUNT)
      count_r <= 32'h0;

  // Read mux; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_r <= 32'h0;
    else if (apb_rd)
    begin
      prdata_r <= 32'h0;
      unique case (paddr)
        `CSRC_OFS_CTRL:   prdata_r[2:0] <= ctrl_r;
        `CSRC_OFS_MASK:   prdata_r[3:0] <= mask_r;
        `CSRC_OFS_STATUS:
        begin
          prdata_r[`CSRC_ST_BUSY] <= (state_r != csrc_pkg::ST_IDLE);
          prdata_r[`CSRC_ST_RESP_HI:`CSRC_ST_RESP_LO] <= r_resp_r;
        end
        `CSRC_OFS_COUNT:  prdata_r <= count_r;
        default:          prdata_r <= 32'h0;
      endcase
    end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  evict_okay_a: assert property (@(posedge pclk) disable iff (!presetn)
    b_valid && req_r.txn == csrc_pkg::TX_EVICT |->
      b_resp == `CSRC_BRESP_OKAY)
    else $error("evict answer not OKAY");

  evict_local_a: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && req_ready && req.txn == csrc_pkg::TX_EVICT |=>
      b_valid && !dn_aw_valid)
    else $error("evict not answered locally");

  no_self_a: assert property (@(posedge pclk) disable iff (!presetn)
    ac_valid |-> ac.target != req_r.src && mask_r[ac.target])
    else $error("snoop sent to initiator");

  nsd_combo_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid && req_r.txn == csrc_pkg::TX_READ_NSD |->
      !(r_resp[`CSRC_RR_IS] && r_resp[`CSRC_RR_PD]))
    else $error("NSD returned shared dirty");

  bits_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid |-> (may_share(req_r.txn) || !r_resp[`CSRC_RR_IS]) &&
      (may_dirty(req_r.txn) || !r_resp[`CSRC_RR_PD]))
    else $error("response bit not permitted");

  mkinv_use_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ac_valid) && pd_r && ctrl_r[`CSRC_CTRL_MKINV] &&
      mkinv_ok(req_r.txn) |->
      ac.snoop == csrc_pkg::SN_MAKE_INVALID)
    else $error("MakeInvalid not used after dirty");

  end_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    ac_valid |-> ac.need == need_state(req_r.txn))
    else $error("wrong end state requested");

  after_snoop_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid && needs_snoop(req_r.txn) |-> done_r && !cr_ready)
    else $error("read answered before snooping ended");

  wu_shared_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid && wu_r && wu_is_r && may_share(req_r.txn) |->
      r_resp[`CSRC_RR_IS])
    else $error("unique shared snoop not reported");

  any_shared_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid && !wu_r && is_r && may_share(req_r.txn) |->
      r_resp[`CSRC_RR_IS])
    else $error("shared snoop not reported");

  none_shared_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid && !wu_r && !is_r && !dt_r |-> !r_resp[`CSRC_RR_IS])
    else $error("IsShared set without cause");

  dirty_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    r_valid && pd_r && !mu_need_r && may_dirty(req_r.txn) |->
      r_resp[`CSRC_RR_PD])
    else $error("PassDirty dropped");

  wr_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    dn_b_valid && dn_b_ready |=> b_valid && b_resp == $past(dn_b_resp))
    else $error("write response not forwarded");

  ac_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ac_valid && !ac_ready |=> ac_valid && $stable(ac))
    else $error("snoop request changed while pending");

endmodule

// ==== csrc_map.svh ====
// Register offsets, field positions, reset values and bit positions
`ifndef CSRC_MAP_SVH
`define CSRC_MAP_SVH
// ********************************************************************
// Register map (byte addresses)
// ********************************************************************
`define CSRC_OFS_CTRL        12'h000
`define CSRC_OFS_MASK        12'h004
`define CSRC_OFS_STATUS      12'h008
`define CSRC_OFS_COUNT       12'h00c
// ********************************************************************
// Fields and reset values
// ********************************************************************
`define CSRC_CTRL_EN         0
`define CSRC_CTRL_MKINV      1
`define CSRC_CTRL_SHDATA     2
`define CSRC_CTRL_RST        3'h1
`define CSRC_MASK_RST        4'hf
`define CSRC_ST_BUSY         0
`define CSRC_ST_RESP_LO      1
`define CSRC_ST_RESP_HI      4
// ********************************************************************
// Snoop and read response bits
// ********************************************************************
`define CSRC_CR_DT           0
`define CSRC_CR_PD           2
`define CSRC_CR_IS           3
`define CSRC_CR_WU           4
`define CSRC_RR_PD           2
`define CSRC_RR_IS           3
`define CSRC_BRESP_OKAY      2'h0
`define CSRC_RESP_OKAY       2'h0
`define CSRC_LAST_MID        2'h3
`endif

// ==== csrc_pkg.sv ====
// Types shared by the snoop and response controller
package csrc_pkg;
  // Transactions from an initiating master
  typedef enum logic [4:0] {
    TX_READ_NO_SNOOP, TX_READ_ONCE, TX_READ_CLEAN, TX_READ_NSD,
    TX_READ_SHARED, TX_READ_UNIQUE, TX_CLEAN_UNIQUE, TX_MAKE_UNIQUE,
    TX_CLEAN_SHARED, TX_CLEAN_INVALID, TX_MAKE_INVALID,
    TX_WRITE_NO_SNOOP, TX_WRITE_UNIQUE, TX_WRITE_LINE_UNIQUE,
    TX_WRITE_BACK, TX_WRITE_CLEAN, TX_WRITE_EVICT, TX_EVICT
  } csrc_txn_e;
  // Snoop requests sent to cached masters
  typedef enum logic [2:0] {
    SN_READ_ONCE, SN_READ_CLEAN, SN_READ_NSD, SN_READ_SHARED,
    SN_READ_UNIQUE, SN_CLEAN_INVALID, SN_MAKE_INVALID, SN_CLEAN_SHARED
  } csrc_snoop_e;
  // Line state the snooped cache must end in
  typedef enum logic [1:0] {
    END_NONE, END_SHARED_OR_INV, END_CLEAN_OR_INV, END_INVALID
  } csrc_end_e;
  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_PICK, ST_SNOOP, ST_WAITCR, ST_DONE, ST_MEMUPD,
    ST_DOWN, ST_WAITB, ST_RRESP, ST_BRESP
  } csrc_state_e;
  typedef struct packed {
    csrc_txn_e   txn;
    logic [1:0]  src;
    logic [31:0] addr;
  } csrc_req_s;
  typedef struct packed {
    csrc_snoop_e snoop;
    csrc_end_e   need;
    logic [1:0]  target;
    logic [31:0] addr;
  } csrc_snp_s;
endpackage

// ==== csrc_far.sv ====
// Model of snooped caches, downstream slave and memory port
`timescale 1ns/1ps
module csrc_far (
  // Clock, reset and settings
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                slow,
  input  wire logic [19:0]         rtab,
  input  wire logic [1:0]          bcfg,
  // Requests from the controller
  input  wire logic                ac_valid,
  input  wire csrc_pkg::csrc_snp_s ac,
  input  wire logic                cr_ready,
  input  wire logic                dn_aw_valid,
  input  wire logic                dn_b_ready,
  // Answers to the controller
  output logic                     ac_ready,
  output logic                     cr_valid,
  output logic      [4:0]          cr_resp,
  output logic                     dn_aw_ready,
  output logic                     dn_b_valid,
  output logic      [1:0]          dn_b_resp,
  output logic                     mu_ready
);
  // Readies stall at random in slow phases
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {ac_ready, dn_aw_ready, mu_ready} <= 3'h0;
    else
      {ac_ready, dn_aw_ready, mu_ready} <= slow ? 3'($urandom) : 3'h7;
  // Answers stand until taken; released lines invert so stale data shows
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {cr_valid, cr_resp, dn_b_valid, dn_b_resp} <= 9'h0;
    else
    begin
      if (ac_valid && ac_ready)
        {cr_valid, cr_resp} <= {1'b1, rtab[ac.target*5 +: 5]};
      else if (cr_valid && cr_ready)
        {cr_valid, cr_resp} <= {1'b0, ~cr_resp};
      if (dn_aw_valid && dn_aw_ready)
        {dn_b_valid, dn_b_resp} <= {1'b1, bcfg};
      else if (dn_b_valid && dn_b_ready)
        {dn_b_valid, dn_b_resp} <= {1'b0, ~dn_b_resp};
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the snoop and response controller
`timescale 1ns/1ps
`include "csrc_map.svh"
module tb;
  logic                pclk, presetn, psel, penable, pwrite, pready, e;
  logic                req_valid, req_ready, ac_valid, ac_ready, slow;
  logic                cr_valid, cr_ready, r_valid, r_ready, b_valid;
  logic                b_ready, dn_aw_valid, dn_aw_ready, dn_b_valid;
  logic                dn_b_ready, pslverr, mu_valid, mu_ready;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, q;
  logic [4:0]          cr_resp, eq[$];
  logic [3:0]          r_resp, mask, tq[$];
  logic [1:0]          b_resp, dn_b_resp, bcfg;
  logic [2:0]          ctrl;
  logic [19:0]         rtab, tab;
  csrc_pkg::csrc_req_s req;
  csrc_pkg::csrc_snp_s ac;
  int                  n_fail, num_checks, nsent;
  csrc_ctrl dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready, .req,
    .ac_valid, .ac_ready, .ac, .cr_valid, .cr_ready, .cr_resp, .r_valid,
    .r_ready, .r_resp, .b_valid, .b_ready, .b_resp, .dn_aw_valid,
    .dn_aw_ready, .dn_aw(), .dn_b_valid, .dn_b_ready, .dn_b_resp,
    .mu_valid, .mu_ready, .mu_addr());
  csrc_far far_u (.pclk, .presetn, .slow, .rtab, .bcfg, .ac_valid, .ac,
    .cr_ready, .dn_aw_valid, .dn_b_ready, .ac_ready, .cr_valid, .cr_resp,
    .dn_aw_ready, .dn_b_valid, .dn_b_resp, .mu_ready);
  always #2.5 pclk = ~pclk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected snoop order and answer; kinds by encoding, reads up to 10
  task automatic predict(input logic [4:0] k, input logic [1:0] s);
    logic       wu, wis, ais, adt, apd, stop, sh, pd, snp;
    logic [1:0] nd;
    logic [4:0] c;
    {wu, wis, ais, adt, apd, stop} = 6'h0;
    snp = !(k inside {0, 11, [14:17]});
    nd = k inside {[2:4]} ? 2'h1 : k == 8 ? 2'h2 : k == 1 ? 2'h0 : 2'h3;
    for (int i = 0; i < 4; i++)
      if (snp && !stop && mask[i] && 2'(i) != s)
      begin
        c = tab[i*5 +: 5];
        tq.push_back({nd, 2'(i)});
        if (c[4]) {wu, wis} = {1'b1, c[3]};
        {ais, adt, apd} = {ais | c[3], adt | c[0], apd | c[2]};
        stop = c[4] || (c[0] && k inside {[1:4]}) || (c[2] && k == 8);
      end
    sh = k inside {[1:4], 8} && (wu ? wis : ais || (ctrl[2] && adt));
    pd = apd && k inside {[3:5]} && !(k == 3 && sh);
    eq.push_back(k <= 10 ? {1'b0, sh, pd, 2'h0} : {3'h4, k == 17 ? 2'h0 : bcfg});
  endtask
  // One APB transfer; the request holds until pready at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  // One transaction with fresh snoop answers; waits for its answer
  task automatic send(input logic [4:0] k, input logic [1:0] s);
    for (int i = 0; i < 20; i += 5)
    begin
      tab[i +: 5] = 5'($urandom) & 5'h1d;
      tab[i] = tab[i] | tab[i + 2];
    end
    rtab <= tab;
    bcfg <= 2'($urandom);
    @(posedge pclk);
    predict(k, s);
    req_valid <= 1'b1;
    req <= '{txn: csrc_pkg::csrc_txn_e'(k), src: s, addr: $urandom};
    do @(posedge pclk); while (!req_ready);
    req_valid <= 1'b0;
    nsent++;
    for (int n = 0; n < 400 && eq.size() > 0; n++) @(posedge pclk);
    cmp(32'(eq.size() + tq.size()), 32'h0);
    eq.delete();
    tq.delete();
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Answers and snoops are matched against the oldest note
  always @(posedge pclk)
  begin
    if (r_valid && r_ready)
      cmp(32'({1'b0, r_resp}), eq.size() ? 32'(eq.pop_front()) : 'x);
    if (b_valid && b_ready)
      cmp(32'({3'h4, b_resp}), eq.size() ? 32'(eq.pop_front()) : 'x);
    if (ac_valid && ac_ready)
      cmp(32'({ac.need, ac.target}), tq.size() ? 32'(tq.pop_front()) : 'x);
  end
  // Answer readies stall at random in slow phases
  always @(posedge pclk)
    {r_ready, b_ready} <= slow ? 2'($urandom) : 2'h3;
  // Hang guard
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, req_valid} = '0;
    {req, slow, rtab, bcfg, r_ready, b_ready, ctrl, mask} = '0;
    void'($urandom(32'hfc89));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`CSRC_OFS_CTRL, 1'b0, 32'h0);
    cmp(q, 32'(`CSRC_CTRL_RST));
    apb(`CSRC_OFS_MASK, 1'b0, 32'h0);
    cmp(q, 32'(`CSRC_MASK_RST));
    apb(12'h010, 1'b0, 32'h0);
    cmp({q[30:0], e}, 32'h1);
    // Phases vary stalls, share-on-data, dirty mode and present masters
    for (int p = 0; p < 8; p++)
    begin
      slow <= p[0];
      ctrl = {p[2:1], 1'b1};
      mask = 4'($urandom);
      apb(`CSRC_OFS_CTRL, 1'b1, 32'(ctrl));
      apb(`CSRC_OFS_MASK, 1'b1, 32'(mask));
      for (int t = 0; t < 40; t++)
        send(5'(t < 18 ? t : $urandom_range(17)), 2'($urandom));
    end
    apb(`CSRC_OFS_COUNT, 1'b0, 32'h0);
    cmp(q, 32'(nsent));
    print_verdict();
  end
endmodule
